//--- rtl/fblf_pkg.sv
// Constants for the queue level and bit framing register bank.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one register per word.
package fblf_pkg;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_FILL_LEVEL  = 6'h0a;
   localparam logic [5:0] IDX_WARN_THRESH = 6'h0b;
   localparam logic [5:0] IDX_MISC_CTRL   = 6'h0c;
   localparam logic [5:0] IDX_BIT_FRAMING = 6'h0d;
   localparam logic [5:0] IDX_PRIM_STATUS = 6'h10;
   localparam logic [5:0] IDX_IRQ_STATUS  = 6'h11;
   localparam logic [5:0] IDX_IRQ_CLEAR   = 6'h12;
   localparam logic [5:0] IDX_IRQ_ENABLE  = 6'h13;

   localparam logic [7:0] ADDR_FILL_LEVEL  = {IDX_FILL_LEVEL, 2'b00};
   localparam logic [7:0] ADDR_WARN_THRESH = {IDX_WARN_THRESH, 2'b00};
   localparam logic [7:0] ADDR_MISC_CTRL   = {IDX_MISC_CTRL, 2'b00};
   localparam logic [7:0] ADDR_BIT_FRAMING = {IDX_BIT_FRAMING, 2'b00};
   localparam logic [7:0] ADDR_PRIM_STATUS = {IDX_PRIM_STATUS, 2'b00};
   localparam logic [7:0] ADDR_IRQ_STATUS  = {IDX_IRQ_STATUS, 2'b00};
   localparam logic [7:0] ADDR_IRQ_CLEAR   = {IDX_IRQ_CLEAR, 2'b00};
   localparam logic [7:0] ADDR_IRQ_ENABLE  = {IDX_IRQ_ENABLE, 2'b00};

   // Field positions
   localparam int BIT_QUEUE_FLUSH   = 7;
   localparam int BIT_TIMER_HALT    = 7;
   localparam int BIT_TIMER_LAUNCH  = 6;
   localparam int BIT_COPY_ID       = 5;
   localparam int BIT_INITIATOR     = 4;
   localparam int BIT_SEND_TRIGGER  = 7;
   localparam int POS_RX_ALIGN      = 4;
   localparam int POS_TX_TAIL       = 0;

   // Interrupt status bits
   localparam int IRQ_OVERFLOW   = 0;
   localparam int IRQ_NEAR_FULL  = 1;
   localparam int IRQ_NEAR_EMPTY = 2;
   localparam int IRQ_COPY_DONE  = 3;
   localparam int IRQ_WIDTH      = 4;

   // Values after reset
   localparam logic [5:0] RST_WARN_THRESH = 6'h08;
   localparam logic [6:0] RST_FILL_COUNT  = 7'h00;
   localparam logic [2:0] RST_FIELD3      = 3'h0;

   // Sizes and counts
   localparam logic [7:0] QUEUE_DEPTH  = 8'h40;
   localparam logic [3:0] ID_LAST_IDX  = 4'h9;
   localparam logic [3:0] TX_FULL_BYTE = 4'h8;

   // Modem state codes shown in the primary status register
   localparam logic [2:0] MODEM_CODE_IDLE = 3'h0;
   localparam logic [2:0] MODEM_CODE_WAIT = 3'h1;
   localparam logic [2:0] MODEM_CODE_SEND = 3'h3;

   typedef enum logic [2:0] {
      MS_IDLE = 3'b001,
      MS_WAIT = 3'b010,
      MS_SEND = 3'b100
   } fblf_modem_t;

endpackage : fblf_pkg

//--- rtl/fblf_rx_align.sv
// Receive bit packer: places incoming bits into queue bytes at an alignment.
// Assumes bit strobes come from modem logic on clk_sys, one bit per pulse.
`timescale 1ns/1ps
module fblf_rx_align
   import fblf_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic [2:0] align,
   input  wire logic       frame_start,
   input  wire logic       bit_valid,
   input  wire logic       bit_in,
   input  wire logic       frame_end,
   output logic            byte_wr_r,
   output logic [7:0]      byte_r,
   output logic [2:0]      tail_r
);

   logic [2:0] pos_r;
   logic [2:0] pos_nxt;
   logic [7:0] acc_r;
   logic [7:0] acc_nxt;
   logic [7:0] bit_word;
   logic [2:0] pos_after;
   logic       full_w;
   logic       take_bit;

   // A start strobe discards any bit in the same cycle
   assign take_bit  = bit_valid && !frame_start;
   assign bit_word  = acc_r | (8'(bit_in) << pos_r);
   assign full_w    = take_bit && (pos_r == 3'h7);
   assign pos_after = take_bit ? pos_r + 3'h1 : pos_r;
   assign pos_nxt   = frame_start ? align : (frame_end ? 3'h0 : pos_after);
   assign acc_nxt   = (frame_start || frame_end || full_w) ? 8'h00 :
                      (take_bit ? bit_word : acc_r);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pos_r     <= 3'h0;
         acc_r     <= 8'h00;
         byte_wr_r <= 1'b0;
         byte_r    <= 8'h00;
         tail_r    <= RST_FIELD3;
      end else begin
         pos_r     <= pos_nxt;
         acc_r     <= acc_nxt;
         // Full byte after bit seven, else a partial byte at frame end
         byte_wr_r <= full_w || (frame_end && !frame_start && pos_after != 3'h0);
         byte_r    <= take_bit ? bit_word : acc_r;
         if (frame_end && !frame_start) begin
            tail_r <= full_w ? 3'h0 : pos_after;
         end
      end
   end

   property p_align_start;
      @(posedge clk_sys) disable iff (rst)
      frame_start |=> pos_r == $past(align);
   endproperty
   a_align_start: assert property (p_align_start) else $error("first bit position not align");

   property p_wrap_byte;
      @(posedge clk_sys) disable iff (rst)
      (take_bit && !frame_end && pos_r == 3'h7) |=> (byte_wr_r && pos_r == 3'h0);
   endproperty
   a_wrap_byte: assert property (p_wrap_byte) else $error("no wrap to bit zero");

   property p_tail_count;
      @(posedge clk_sys) disable iff (rst)
      (frame_end && !frame_start && !bit_valid) |=> tail_r == $past(pos_r);
   endproperty
   a_tail_count: assert property (p_tail_count) else $error("tail bit count wrong");

endmodule : fblf_rx_align

//--- rtl/fblf_regs.sv
// Queue level and bit framing register bank behind an Avalon-MM slave.
// Assumes queue storage, timer and modem sit outside on clk_sys.
//
// Overview of operation
// - Flush write clears pointers; clears overflow unless a new one arrives; reads zero
// - Seven-bit fill count tracks pushes and pops
// - Near-full when free space at most threshold
// - Near-empty when fill count at most threshold
// - Timer halt bit stops timer, reads zero
// - Timer launch bit starts timer unless halt bit set, reads zero
// - Copy ten identifier bytes, then self-clear
// - Role bit one is initiator, zero target
// - Report valid bits of last received byte
// - Send trigger starts transmit only in transceive
// - Received bits start at alignment, wrap bytes
// - Transmit only tail bits of final byte
// - Queue holds at most sixty-four bytes
// - Modem code 001 while waiting for trigger
`timescale 1ns/1ps
module fblf_regs
   import fblf_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        host_queue_push,
   input  wire logic        host_queue_pop,
   input  wire logic [79:0] stored_target_identifier,
   input  wire logic        rx_frame_start,
   input  wire logic        rx_bit_valid,
   input  wire logic        rx_bit,
   input  wire logic        rx_frame_end,
   input  wire logic        transceive_active,
   input  wire logic        tx_done,
   output logic             queue_flush,
   output logic             id_byte_wr,
   output logic [7:0]       id_byte,
   output logic             rx_byte_wr,
   output logic [7:0]       rx_byte,
   output logic             tx_start,
   output logic [3:0]       tx_final_bits,
   output logic             timer_halt,
   output logic             timer_launch,
   output logic             timer_running,
   output logic             initiator_mode,
   output logic             near_full_alert,
   output logic             near_empty_alert,
   output logic             overflow_error,
   output logic             irq
);

   logic [6:0]           fill_r;
   logic [6:0]           fill_nxt;
   logic [5:0]           thresh_r;
   logic [2:0]           rx_align_r;
   logic [2:0]           tx_tail_r;
   logic [2:0]           rx_tail;
   logic                 id_busy_r;
   logic [3:0]           id_idx_r;
   logic [IRQ_WIDTH-1:0] irq_st_r;
   logic [IRQ_WIDTH-1:0] irq_en_r;
   logic [IRQ_WIDTH-1:0] irq_ev;
   logic [IRQ_WIDTH-1:0] irq_clr;
   logic [7:0]           rd_mux;
   logic [7:0]           fill_sum;
   logic [7:0]           fill_net;
   logic [7:0]           free_space;
   logic [1:0]           pushes;
   logic                 pop_ok;
   logic                 over_ev;
   logic                 acc;
   logic                 wr_acc;
   logic                 rd_take;
   logic                 wr_level;
   logic                 wr_thresh;
   logic                 wr_misc;
   logic                 wr_frame;
   logic                 wr_clear;
   logic                 wr_enable;
   logic                 halt_req;
   logic                 launch_req;
   logic                 copy_start;
   logic                 trigger_req;
   logic                 near_full_nxt;
   logic                 near_empty_nxt;
   logic [2:0]           modem_code;
   fblf_modem_t          modem_r;
   fblf_modem_t          modem_nxt;

   // Bus handshake: first cycle waits, second answers
   assign acc     = (avs_read || avs_write) && !avs_waitrequest;
   assign wr_acc  = acc && avs_write && avs_byteenable[0];
   assign rd_take = avs_read && avs_waitrequest;

   assign wr_level  = wr_acc && (avs_address == ADDR_FILL_LEVEL);
   assign wr_thresh = wr_acc && (avs_address == ADDR_WARN_THRESH);
   assign wr_misc   = wr_acc && (avs_address == ADDR_MISC_CTRL);
   assign wr_frame  = wr_acc && (avs_address == ADDR_BIT_FRAMING);
   assign wr_clear  = wr_acc && (avs_address == ADDR_IRQ_CLEAR);
   assign wr_enable = wr_acc && (avs_address == ADDR_IRQ_ENABLE);

   assign halt_req    = wr_misc && avs_writedata[BIT_TIMER_HALT];
   assign launch_req  = wr_misc && avs_writedata[BIT_TIMER_LAUNCH];
   assign copy_start  = wr_misc && avs_writedata[BIT_COPY_ID] && !id_busy_r;
   assign trigger_req = wr_frame && avs_writedata[BIT_SEND_TRIGGER];

   // Write-only bits always read back as zero
   always_comb begin
      if (avs_address == ADDR_FILL_LEVEL) begin
         rd_mux = {1'b0, fill_r};
      end else if (avs_address == ADDR_WARN_THRESH) begin
         rd_mux = {2'b00, thresh_r};
      end else if (avs_address == ADDR_MISC_CTRL) begin
         rd_mux = {2'b00, id_busy_r, initiator_mode, 1'b0, rx_tail};
      end else if (avs_address == ADDR_BIT_FRAMING) begin
         rd_mux = {1'b0, rx_align_r, 1'b0, tx_tail_r};
      end else if (avs_address == ADDR_PRIM_STATUS) begin
         rd_mux = {1'b0, overflow_error, near_full_alert, near_empty_alert, 1'b0, modem_code};
      end else if (avs_address == ADDR_IRQ_STATUS) begin
         rd_mux = {4'h0, irq_st_r};
      end else if (avs_address == ADDR_IRQ_ENABLE) begin
         rd_mux = {4'h0, irq_en_r};
      end else begin
         rd_mux = 8'h00;
      end
   end

   // Fill count; pops on an empty queue are dropped, pushes past 64 overflow
   assign pushes     = 2'(host_queue_push) + 2'(id_byte_wr);
   assign fill_sum   = {1'b0, fill_r} + 8'(pushes + 2'(rx_byte_wr));
   assign pop_ok     = host_queue_pop && (fill_sum != 8'h00);
   assign fill_net   = fill_sum - 8'(pop_ok);
   assign over_ev    = fill_net > QUEUE_DEPTH;
   assign fill_nxt   = wr_level && avs_writedata[BIT_QUEUE_FLUSH] ? RST_FILL_COUNT :
                       (over_ev ? QUEUE_DEPTH[6:0] : fill_net[6:0]);
   assign free_space = QUEUE_DEPTH - {1'b0, fill_nxt};
   assign near_full_nxt  = free_space <= {2'b00, thresh_r};
   assign near_empty_nxt = {1'b0, fill_nxt} <= {2'b00, thresh_r};

   assign irq_ev[IRQ_OVERFLOW]   = over_ev;
   assign irq_ev[IRQ_NEAR_FULL]  = near_full_nxt && !near_full_alert;
   assign irq_ev[IRQ_NEAR_EMPTY] = near_empty_nxt && !near_empty_alert;
   assign irq_ev[IRQ_COPY_DONE]  = id_busy_r && (id_idx_r == ID_LAST_IDX);
   assign irq_clr = wr_clear ? avs_writedata[IRQ_WIDTH-1:0] : '0;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
         if (rd_take) begin
            avs_readdata <= {24'h00_0000, rd_mux};
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fill_r           <= RST_FILL_COUNT;
         near_full_alert  <= 1'b0;
         near_empty_alert <= 1'b1;
         overflow_error   <= 1'b0;
         queue_flush      <= 1'b0;
         irq_st_r         <= '0;
         irq_en_r         <= '0;
         irq              <= 1'b0;
      end else begin
         fill_r           <= fill_nxt;
         near_full_alert  <= near_full_nxt;
         near_empty_alert <= near_empty_nxt;
         queue_flush      <= wr_level && avs_writedata[BIT_QUEUE_FLUSH];
         // New overflow wins over a flush in the same cycle
         overflow_error   <= over_ev ||
                             (overflow_error && !queue_flush_req(wr_level, avs_writedata));
         irq_st_r         <= (irq_st_r & ~irq_clr) | irq_ev;
         if (wr_enable) begin
            irq_en_r <= avs_writedata[IRQ_WIDTH-1:0];
         end
         irq              <= |(((irq_st_r & ~irq_clr) | irq_ev) & irq_en_r);
      end
   end

   // Inputs as arguments so that assertions see sampled, not updated, values
   function automatic logic queue_flush_req(input logic wr, input logic [31:0] data);
      return wr && data[BIT_QUEUE_FLUSH];
   endfunction : queue_flush_req

   // Control fields and timer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         thresh_r       <= RST_WARN_THRESH;
         rx_align_r     <= RST_FIELD3;
         tx_tail_r      <= RST_FIELD3;
         tx_final_bits  <= TX_FULL_BYTE;
         initiator_mode <= 1'b0;
         timer_running  <= 1'b0;
         timer_halt     <= 1'b0;
         timer_launch   <= 1'b0;
      end else begin
         if (wr_thresh) begin
            thresh_r <= avs_writedata[5:0];
         end
         if (wr_frame) begin
            rx_align_r    <= avs_writedata[POS_RX_ALIGN +: 3];
            tx_tail_r     <= avs_writedata[POS_TX_TAIL +: 3];
            tx_final_bits <= (avs_writedata[POS_TX_TAIL +: 3] == 3'h0) ? TX_FULL_BYTE :
                             {1'b0, avs_writedata[POS_TX_TAIL +: 3]};
         end
         if (wr_misc) begin
            initiator_mode <= avs_writedata[BIT_INITIATOR];
         end
         timer_halt   <= halt_req;
         timer_launch <= launch_req && !halt_req;
         if (halt_req) begin
            timer_running <= 1'b0;
         end else if (launch_req) begin
            timer_running <= 1'b1;
         end
      end
   end

   // Identifier copy, one byte per cycle, low byte first
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         id_busy_r  <= 1'b0;
         id_idx_r   <= 4'h0;
         id_byte_wr <= 1'b0;
         id_byte    <= 8'h00;
      end else begin
         id_byte_wr <= id_busy_r;
         if (id_busy_r) begin
            id_byte  <= stored_target_identifier[{id_idx_r, 3'b000} +: 8];
            id_idx_r <= id_idx_r + 4'h1;
            if (id_idx_r == ID_LAST_IDX) begin
               id_busy_r <= 1'b0;
            end
         end else if (copy_start) begin
            id_busy_r <= 1'b1;
            id_idx_r  <= 4'h0;
         end
      end
   end

   // Transceive flow; a trigger outside the wait state is ignored
   always_comb begin
      modem_nxt = modem_r;
      case (modem_r)
         MS_IDLE: begin
            if (transceive_active) modem_nxt = MS_WAIT;
         end
         MS_WAIT: begin
            if (!transceive_active) modem_nxt = MS_IDLE;
            else if (trigger_req) modem_nxt = MS_SEND;
         end
         MS_SEND: begin
            if (!transceive_active) modem_nxt = MS_IDLE;
            else if (tx_done) modem_nxt = MS_WAIT;
         end
         default: modem_nxt = MS_IDLE;
      endcase
   end

   assign modem_code = (modem_r == MS_WAIT) ? MODEM_CODE_WAIT :
                       (modem_r == MS_SEND) ? MODEM_CODE_SEND : MODEM_CODE_IDLE;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         modem_r  <= MS_IDLE;
         tx_start <= 1'b0;
      end else begin
         modem_r  <= modem_nxt;
         tx_start <= (modem_r == MS_WAIT) && transceive_active && trigger_req;
      end
   end

   fblf_rx_align u_rx_align (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .align       (rx_align_r),
      .frame_start (rx_frame_start),
      .bit_valid   (rx_bit_valid),
      .bit_in      (rx_bit),
      .frame_end   (rx_frame_end),
      .byte_wr_r   (rx_byte_wr),
      .byte_r      (rx_byte),
      .tail_r      (rx_tail)
   );

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   property p_flush_clears;
      queue_flush_req(wr_level, avs_writedata) |=> (fill_r == 7'h00) ##0 queue_flush;
   endproperty
   a_flush_clears: assert property (p_flush_clears) else $error("flush did not clear");

   property p_flush_reads_zero;
      (rd_take && avs_address == ADDR_FILL_LEVEL) |=> !avs_readdata[BIT_QUEUE_FLUSH];
   endproperty
   a_flush_reads_zero: assert property (p_flush_reads_zero) else $error("flush bit read 1");

   property p_count_push;
      (host_queue_push && !host_queue_pop && !id_byte_wr && !rx_byte_wr &&
       !queue_flush_req(wr_level, avs_writedata) && fill_r < 7'h40) |=>
      fill_r == $past(fill_r) + 7'h01;
   endproperty
   a_count_push: assert property (p_count_push) else $error("count did not increment");

   property p_near_full;
      ##1 near_full_alert == ((8'h40 - {1'b0, $past(fill_nxt)}) <= {2'b00, $past(thresh_r)});
   endproperty
   a_near_full: assert property (p_near_full) else $error("near-full alert wrong");

   property p_near_empty;
      $stable(thresh_r) |-> near_empty_alert == (fill_r <= {1'b0, thresh_r});
   endproperty
   a_near_empty: assert property (p_near_empty) else $error("near-empty alert wrong");

   property p_halt_wins;
      halt_req |=> !timer_running && timer_halt && !timer_launch;
   endproperty
   a_halt_wins: assert property (p_halt_wins) else $error("halt did not stop timer");

   property p_launch;
      (launch_req && !halt_req) |=> timer_running && timer_launch;
   endproperty
   a_launch: assert property (p_launch) else $error("launch did not start timer");

   property p_copy_ten;
      copy_start |=> ##1 id_byte_wr [*8] ##1 id_byte_wr ##1 id_byte_wr ##1 !id_byte_wr;
   endproperty
   a_copy_ten: assert property (p_copy_ten) else $error("identifier copy not ten bytes");

   property p_role;
      wr_misc |=> initiator_mode == $past(avs_writedata[BIT_INITIATOR]);
   endproperty
   a_role: assert property (p_role) else $error("role bit not taken");

   property p_trigger_only_waiting;
      tx_start |-> $past(modem_r) == MS_WAIT && $past(trigger_req);
   endproperty
   a_trigger_only_waiting: assert property (p_trigger_only_waiting) else $error("stray start");

   property p_wait_code;
      (modem_r == MS_WAIT) |-> modem_code == 3'h1;
   endproperty
   a_wait_code: assert property (p_wait_code) else $error("wait code not 001");

   property p_fill_max;
      fill_r <= 7'h40;
   endproperty
   a_fill_max: assert property (p_fill_max) else $error("fill count above 64");

   c_copy: cover property (copy_start ##11 irq_st_r[IRQ_COPY_DONE]);
   c_send: cover property (modem_r == MS_WAIT ##1 tx_start);
   c_overflow: cover property (over_ev ##1 overflow_error);
   c_irq: cover property (irq ##[1:20] wr_clear);

endmodule : fblf_regs

//--- sim/fblf_modem_model.sv
// Modem-side partner: receive bit frames, transceive flag, send completion.
// Assumes the bench calls its tasks just after a rising clk_sys edge.
`timescale 1ns/1ps
module fblf_modem_model (
   input  wire logic clk_sys,
   input  wire logic tx_start,
   output logic      transceive_active,
   output logic      tx_done,
   output logic      rx_frame_start,
   output logic      rx_bit_valid,
   output logic      rx_bit,
   output logic      rx_frame_end
);
   logic [3:0] dly_r;
   initial begin
      {transceive_active, tx_done, rx_frame_start, rx_bit_valid, rx_frame_end} = '0;
      rx_bit = 1'b0;
      dly_r  = 4'h0;
   end
   // Send finishes a few cycles after the trigger reaches the modem
   always @(posedge clk_sys) begin
      if (tx_start === 1'b1) dly_r <= 4'h4;
      else if (dly_r != 4'h0) dly_r <= dly_r - 4'h1;
      tx_done <= (dly_r == 4'h1);
   end
   task automatic set_xcv(input logic v);
      transceive_active <= v;
      @(posedge clk_sys);
   endtask : set_xcv
   task automatic rx_frame(input int n, input logic [7:0] b);
      rx_frame_start <= 1'b1;
      @(posedge clk_sys);
      rx_frame_start <= 1'b0;
      for (int i = 0; i < n; i++) begin
         rx_bit_valid <= 1'b1;
         rx_bit       <= b[i];
         @(posedge clk_sys);
      end
      // Idle data line flips so a stray sample never looks valid
      rx_bit_valid <= 1'b0;
      rx_bit       <= ~b[n-1];
      rx_frame_end <= 1'b1;
      @(posedge clk_sys);
      rx_frame_end <= 1'b0;
   endtask : rx_frame
endmodule : fblf_modem_model

//--- sim/tb_top.sv
// Self-checking bench for the queue level and bit framing register bank.
// Assumes an Avalon-MM master with one wait cycle per access.
`timescale 1ns/1ps
`define chk(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb_top;
   import fblf_pkg::*;
   logic        clk_sys = 1'b0, rst = 1'b1;
   logic [7:0]  avs_address = 8'h00;
   logic [3:0]  avs_byteenable = 4'h1;
   logic        avs_read = 1'b0, avs_write = 1'b0, host_queue_push = 1'b0, host_queue_pop = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, d;
   logic [79:0] stored_target_identifier;
   logic        avs_waitrequest, transceive_active, tx_done, rx_frame_start, rx_bit_valid;
   logic        rx_bit, rx_frame_end, queue_flush, id_byte_wr, rx_byte_wr, tx_start, timer_halt;
   logic        timer_launch, timer_running, initiator_mode, near_full_alert;
   logic        near_empty_alert, overflow_error, irq;
   logic [7:0]  id_byte, rx_byte, idq[$], rxq[$];
   logic [3:0]  tx_final_bits;
   int          n_fail = 0, compares = 0, n_flush = 0, n_halt = 0, n_launch = 0, n_tx = 0;
   always #2.5 clk_sys = ~clk_sys;
   fblf_regs dut_u (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .host_queue_push(host_queue_push), .host_queue_pop(host_queue_pop),
      .stored_target_identifier(stored_target_identifier), .rx_frame_start(rx_frame_start),
      .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit), .rx_frame_end(rx_frame_end),
      .transceive_active(transceive_active), .tx_done(tx_done), .queue_flush(queue_flush),
      .id_byte_wr(id_byte_wr), .id_byte(id_byte), .rx_byte_wr(rx_byte_wr), .rx_byte(rx_byte),
      .tx_start(tx_start), .tx_final_bits(tx_final_bits), .timer_halt(timer_halt),
      .timer_launch(timer_launch), .timer_running(timer_running),
      .initiator_mode(initiator_mode), .near_full_alert(near_full_alert),
      .near_empty_alert(near_empty_alert), .overflow_error(overflow_error), .irq(irq));
   fblf_modem_model modem_u (.clk_sys(clk_sys), .tx_start(tx_start),
      .transceive_active(transceive_active), .tx_done(tx_done),
      .rx_frame_start(rx_frame_start), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
      .rx_frame_end(rx_frame_end));
   always @(posedge clk_sys) begin
      if (queue_flush === 1'b1) n_flush++;
      if (timer_halt === 1'b1) n_halt++;
      if (timer_launch === 1'b1) n_launch++;
      if (tx_start === 1'b1) n_tx++;
      if (id_byte_wr === 1'b1) idq.push_back(id_byte);
      if (rx_byte_wr === 1'b1) rxq.push_back(rx_byte);
   end
   task automatic end_sim;
      if (n_fail == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : end_sim
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : wt
   task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] v);
      avs_address   <= a;
      avs_writedata <= {24'h00_0000, v};
      avs_write     <= w;
      avs_read      <= ~w;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clk_sys);
   endtask : acc
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      acc(a, 1'b1, v);
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string nm);
      acc(a, 1'b0, 8'h00);
      `chk(nm, e, d & m)
   endtask : rc
   task automatic push(input int n);
      repeat (n) begin
         host_queue_push <= 1'b1;
         @(posedge clk_sys);
      end
      host_queue_push <= 1'b0;
      wt(3);
   endtask : push
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_fail++;
      end_sim();
   end
   initial begin
      for (int i = 0; i < 10; i++) stored_target_identifier[8*i+:8] <= 8'h10 + 8'(i);
      wt(6);
      rst <= 1'b0;
      wt(1);
      rc(ADDR_FILL_LEVEL, 32'hff, 32'h00, "level");
      rc(ADDR_WARN_THRESH, 32'hff, 32'h08, "thr");
      rc(ADDR_MISC_CTRL, 32'hff, 32'h00, "misc");
      rc(ADDR_BIT_FRAMING, 32'hff, 32'h00, "framing");
      rc(8'h00, 32'hffff_ffff, 32'h0000_0000, "unmapped");
      wr(ADDR_WARN_THRESH, 8'h03);
      avs_byteenable <= 4'h0;
      wr(ADDR_WARN_THRESH, 8'h3f);
      avs_byteenable <= 4'h1;
      rc(ADDR_WARN_THRESH, 32'hff, 32'h03, "thr_be");
      push(3);
      `chk("nempty", 1'b1, near_empty_alert)
      push(1);
      `chk("nempty", 1'b0, near_empty_alert)
      push(56);
      `chk("nfull", 1'b0, near_full_alert)
      push(1);
      `chk("nfull", 1'b1, near_full_alert)
      push(3);
      `chk("ovf", 1'b0, overflow_error)
      push(1);
      rc(ADDR_FILL_LEVEL, 32'hff, 32'h40, "level");
      `chk("ovf", 1'b1, overflow_error)
      host_queue_pop <= 1'b1;
      wt(1);
      host_queue_pop <= 1'b0;
      wt(2);
      rc(ADDR_FILL_LEVEL, 32'hff, 32'h3f, "level");
      rc(ADDR_IRQ_STATUS, 32'h1, 32'h1, "irq_st");
      `chk("irq", 1'b0, irq)
      wr(ADDR_IRQ_ENABLE, 8'h01);
      wt(2);
      `chk("irq", 1'b1, irq)
      wr(ADDR_FILL_LEVEL, 8'h80);
      wt(2);
      `chk("flush", 1, n_flush)
      `chk("ovf", 1'b0, overflow_error)
      rc(ADDR_FILL_LEVEL, 32'hff, 32'h00, "level");
      wr(ADDR_IRQ_CLEAR, 8'h01);
      wt(2);
      `chk("irq", 1'b0, irq)
      rc(ADDR_IRQ_STATUS, 32'h1, 32'h0, "irq_st");
      wr(ADDR_MISC_CTRL, 8'h40);
      wt(2);
      `chk("launch", 1, n_launch)
      `chk("run", 1'b1, timer_running)
      rc(ADDR_MISC_CTRL, 32'hff, 32'h00, "misc");
      wr(ADDR_MISC_CTRL, 8'hc0);
      wt(2);
      `chk("halt", 1, n_halt)
      `chk("launch", 1, n_launch)
      `chk("run", 1'b0, timer_running)
      wr(ADDR_MISC_CTRL, 8'h10);
      rc(ADDR_MISC_CTRL, 32'hff, 32'h10, "misc");
      `chk("init", 1'b1, initiator_mode)
      wr(ADDR_MISC_CTRL, 8'h20);
      rc(ADDR_MISC_CTRL, 32'h20, 32'h20, "copy");
      wt(15);
      `chk("init", 1'b0, initiator_mode)
      `chk("ids", 10, idq.size())
      foreach (idq[i]) `chk("id", 8'h10 + 8'(i), idq[i])
      rc(ADDR_MISC_CTRL, 32'h20, 32'h00, "copy");
      rc(ADDR_FILL_LEVEL, 32'hff, 32'h0a, "level");
      rc(ADDR_PRIM_STATUS, 32'h7, 32'h0, "modem");
      wr(ADDR_BIT_FRAMING, 8'h80);
      wt(3);
      `chk("txs", 0, n_tx)
      modem_u.set_xcv(1'b1);
      wt(2);
      rc(ADDR_PRIM_STATUS, 32'h7, 32'h1, "modem");
      wr(ADDR_BIT_FRAMING, 8'h87);
      wt(2);
      `chk("txs", 1, n_tx)
      `chk("txbits", 4'h7, tx_final_bits)
      rc(ADDR_PRIM_STATUS, 32'h7, 32'h3, "modem");
      rc(ADDR_BIT_FRAMING, 32'hff, 32'h07, "framing");
      wt(8);
      rc(ADDR_PRIM_STATUS, 32'h7, 32'h1, "modem");
      wr(ADDR_BIT_FRAMING, 8'h30);
      `chk("txbits", 4'h8, tx_final_bits)
      modem_u.rx_frame(7, 8'h6d);
      wt(3);
      `chk("rxn", 2, rxq.size())
      `chk("rx0", 8'h68, rxq[0] & 8'hf8)
      `chk("rx1", 8'h03, rxq[1] & 8'h07)
      rc(ADDR_MISC_CTRL, 32'h7, 32'h2, "rxtail");
      wr(ADDR_BIT_FRAMING, 8'h00);
      modem_u.rx_frame(8, 8'ha5);
      wt(3);
      `chk("rx2", 8'ha5, rxq[2])
      rc(ADDR_MISC_CTRL, 32'h7, 32'h0, "rxtail");
      end_sim();
   end
endmodule : tb_top
